// ==== gio_defines.vh ====
`ifndef GIO_DEFINES_VH
`define GIO_DEFINES_VH

// ==========================================================
// Register offsets on the plain register port
`define GIO_OFS_P1_DATA 8'h90
`define GIO_OFS_P3_DATA 8'hB0
`define GIO_OFS_P4_DATA 8'hC0
`define GIO_OFS_P1_MODE_HIGH 8'hE2
`define GIO_OFS_P3_MODE_HIGH 8'hE4
`define GIO_OFS_P4_MODE_HIGH 8'hE5
`define GIO_OFS_P1_MODE_LOW 8'hEA
`define GIO_OFS_P3_MODE_LOW 8'hEC
`define GIO_OFS_P4_MODE_LOW 8'hED

// ==========================================================
// Implemented bit positions of each port
`define GIO_P1_MASK 8'hFF
`define GIO_P3_MASK 8'hBF
`define GIO_P4_MASK 8'h07

// ==========================================================
// Pin modes, coded as {pin_mode_bit_low, pin_mode_bit_high}
`define GIO_MODE_QUASI 2'h0
`define GIO_MODE_PUSH 2'h1
`define GIO_MODE_INPUT 2'h2
`define GIO_MODE_OPEN 2'h3

// ==========================================================
// Reset values chosen by the reset-mode code option
`define GIO_LATCH_RST_QUASI 8'hFF
`define GIO_LATCH_RST_INPUT 8'h00
`define GIO_MODE_LOW_RST_QUASI 8'h00
`define GIO_MODE_LOW_RST_INPUT 8'hFF
`define GIO_MODE_HIGH_RST 8'h00

// ==========================================================
// Strong pull-up boost: time in machine cycles, one clock each
`define GIO_STRONG_MC 2
`define GIO_CLK_PER_MC 1
`define GIO_STRONG_CYC (`GIO_STRONG_MC * `GIO_CLK_PER_MC)

`endif

// ==== gio_pin.v ====
`timescale 1ns/10ps
`include "gio_defines.vh"

module gio_pin #(
  parameter RESET_LATCH = 1'b1,
  parameter [1:0] RESET_MODE = 2'h0
) (
  input wire core_clk_i,
  input wire reset_i,
  input wire ce_i,
  input wire pad_i,
  input wire latch_i,
  input wire [1:0] mode_i,
  input wire hold_i,
  input wire hiz_i,
  output reg pad_o,
  output reg pad_oe_o,
  output reg weak_pu_o,
  output reg vweak_pu_o,
  output wire level_o
);

  reg sync1_ff;
  reg sync2_ff;
  reg drv_latch_ff;
  reg [1:0] drv_mode_ff;
  reg [1:0] strong_cnt_ff;
  reg nxt_drv_latch;
  reg [1:0] nxt_drv_mode;
  reg [1:0] nxt_strong_cnt;
  reg nxt_pad;
  reg nxt_oe;
  reg nxt_weak;
  reg nxt_vweak;

  // Boost length; the counter is two bits, so it must stay below 4
  localparam [31:0] STRONG_CYC = `GIO_STRONG_CYC;

  assign level_o = sync2_ff;

  // ==========================================================
  // Drive state follows latch and mode only while not shared
  always @* begin
    nxt_drv_latch = hold_i ? drv_latch_ff : latch_i;
    nxt_drv_mode = hold_i ? drv_mode_ff : mode_i;
    nxt_strong_cnt = (strong_cnt_ff != 2'h0) ?
      strong_cnt_ff - 2'h1 : 2'h0;
    if (nxt_drv_mode == `GIO_MODE_QUASI && !drv_latch_ff &&
        nxt_drv_latch) begin
      nxt_strong_cnt = STRONG_CYC[1:0];
    end
  end

  // ==========================================================
  // Driver enables per mode; pad level drives weak pull-up
  always @* begin
    nxt_pad = 1'b0;
    nxt_oe = 1'b0;
    nxt_weak = 1'b0;
    nxt_vweak = 1'b0;
    case (drv_mode_ff)
      `GIO_MODE_QUASI: begin
        if (drv_latch_ff) begin
          nxt_pad = 1'b1;
          nxt_oe = (strong_cnt_ff != 2'h0);
          nxt_weak = sync2_ff;
          nxt_vweak = 1'b1;
        end else begin
          nxt_oe = 1'b1;
        end
      end
      `GIO_MODE_PUSH: begin
        nxt_pad = drv_latch_ff;
        nxt_oe = 1'b1;
      end
      `GIO_MODE_OPEN: begin
        nxt_oe = !drv_latch_ff;
      end
      default: begin
        nxt_oe = 1'b0;
      end
    endcase
    // Analog use needs every driver off
    if (hiz_i) begin
      nxt_pad = 1'b0;
      nxt_oe = 1'b0;
      nxt_weak = 1'b0;
      nxt_vweak = 1'b0;
    end
  end

  // ==========================================================
  // Input path is gated by ce_i like the rest, so it stops sensing pins while ce_i is low
  always @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      drv_latch_ff <= RESET_LATCH;
      drv_mode_ff <= RESET_MODE;
      strong_cnt_ff <= 2'h0;
      pad_o <= 1'b0;
      pad_oe_o <= 1'b0;
      weak_pu_o <= 1'b0;
      vweak_pu_o <= 1'b0;
    end else if (ce_i) begin
      sync1_ff <= pad_i;
      sync2_ff <= sync1_ff;
      drv_latch_ff <= nxt_drv_latch;
      drv_mode_ff <= nxt_drv_mode;
      strong_cnt_ff <= nxt_strong_cnt;
      pad_o <= nxt_pad;
      pad_oe_o <= nxt_oe;
      weak_pu_o <= nxt_weak;
      vweak_pu_o <= nxt_vweak;
    end
  end

endmodule

// ==== gio_port.v ====
// Summary of operation
// - Two mode bits per pin select quasi, push-pull, input-only or open-drain.
// - Reset loads data latches with FF or 00 per reset-mode option.
// - Reset puts every pin in quasi or input-only mode per option.
// - Pin input sampling never stops, including in power-down; here ce_i low stops it.
// - Mode writes apply only to pins with no shared function enabled.
// - Quasi latch 1: weak pull-up on while pin high, off when pulled low.
// - Quasi latch 1: very weak pull-up always on.
// - Quasi latch rising 0 to 1 turns strong pull-up on two cycles.
// - Push-pull drives strong high for latch 1, low for latch 0.
// - Input-only turns every driver off.
// - Open-drain drives low for latch 0, releases for latch 1.
// - Highest-priority enabled function owns a shared pin.
// - Pin passes down only after the higher function is disabled.
// - While shared, accesses touch only the latch; pin drive holds.
// - Port1 pin 6 is timer2 reload input with ext, run, counter set.
// - Port1 pin 7 is timer2 pin with run and counter select set.
// - Port1 pin 3 is low-voltage-detect input when selected.
// - Port1 pin 2 is external interrupt 2 when enabled.
//
// The strobed register port is this design's own decision.
`timescale 1ns/10ps
`include "gio_defines.vh"

module gio_port #(
  parameter RESET_INPUT_ONLY = 0
) (
  input wire core_clk_i,
  input wire reset_i,
  input wire ce_i,
  input wire [7:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  input wire [23:0] pin_i,
  output wire [23:0] pin_o,
  output wire [23:0] pin_oe_o,
  output wire [23:0] weak_pu_o,
  output wire [23:0] vweak_pu_o,
  output reg [23:0] pin_level_o,
  input wire converter_on_i,
  input wire [2:0] channel_select_i,
  input wire [7:0] analog_channel_enable_i,
  input wire timer2_run_i,
  input wire timer2_counter_select_i,
  input wire timer2_ext_enable_i,
  input wire lvd_pin_select_i,
  input wire ext_irq2_enable_i,
  output reg [7:0] analog_grant_o,
  output reg timer2_ext_pin_grant_o,
  output reg timer2_reload_capture_pin_grant_o,
  output reg low_voltage_detect_pin_grant_o,
  output reg ext_irq2_pin_grant_o
);

  // ==========================================================
  // Reset values picked by the reset-mode code option
  localparam [23:0] IMPL_MASK =
    {`GIO_P4_MASK, `GIO_P3_MASK, `GIO_P1_MASK};
  localparam [7:0] LATCH_RST = RESET_INPUT_ONLY ?
    `GIO_LATCH_RST_INPUT : `GIO_LATCH_RST_QUASI;
  localparam [7:0] MODE_LOW_RST = RESET_INPUT_ONLY ?
    `GIO_MODE_LOW_RST_INPUT : `GIO_MODE_LOW_RST_QUASI;
  localparam [7:0] MODE_HIGH_RST = `GIO_MODE_HIGH_RST;
  localparam [23:0] LATCH_RST_ALL =
    {LATCH_RST, LATCH_RST, LATCH_RST} & IMPL_MASK;
  localparam [23:0] MODE_LOW_RST_ALL =
    {MODE_LOW_RST, MODE_LOW_RST, MODE_LOW_RST} & IMPL_MASK;
  localparam [23:0] MODE_HIGH_RST_ALL =
    {MODE_HIGH_RST, MODE_HIGH_RST, MODE_HIGH_RST} & IMPL_MASK;

  // ==========================================================
  // Port state: data latches and the two mode-bit planes
  reg [23:0] latch_ff;
  reg [23:0] mode_low_ff;
  reg [23:0] mode_high_ff;
  reg [23:0] nxt_latch;
  reg [23:0] nxt_mode_low;
  reg [23:0] nxt_mode_high;
  reg [7:0] nxt_rdata;

  // Sharing state per pin, only port1 has alternate functions
  reg [7:0] an_sel;
  reg t2_pin_en;
  reg t2_reload_en;
  reg [7:0] p1_share;
  reg [7:0] nxt_an_grant;
  reg nxt_t2_pin_grant;
  reg nxt_t2_reload_grant;
  reg nxt_lvd_grant;
  reg nxt_irq2_grant;
  wire [23:0] share;
  wire [23:0] hiz;
  wire [23:0] level;

  // ==========================================================
  // Alternate function enables on port1
  always @* begin
    an_sel = 8'h00;
    an_sel[channel_select_i] = converter_on_i;
    an_sel = an_sel & analog_channel_enable_i;
    t2_pin_en = timer2_run_i &
      timer2_counter_select_i;
    t2_reload_en = timer2_ext_enable_i & timer2_run_i &
      timer2_counter_select_i;
    p1_share = an_sel;
    p1_share[7] = an_sel[7] | t2_pin_en;
    p1_share[6] = an_sel[6] | t2_reload_en;
    p1_share[3] = an_sel[3] | lvd_pin_select_i;
    p1_share[2] = an_sel[2] | ext_irq2_enable_i;
  end

  // ==========================================================
  // Fixed priority: analog first, second-level functions next.
  // A lower function owns the pin only while every higher one
  // is off, so the grant moves on the clock edge after the disable.
  always @* begin
    nxt_an_grant = an_sel;
    nxt_t2_pin_grant = t2_pin_en & ~an_sel[7];
    nxt_t2_reload_grant =
      t2_reload_en & ~an_sel[6];
    nxt_lvd_grant =
      lvd_pin_select_i & ~an_sel[3];
    nxt_irq2_grant =
      ext_irq2_enable_i & ~an_sel[2];
  end

  // Ports 3 and 4 share nothing in this block
  assign share = {16'h0000, p1_share};

  // Analog channels take the pad with all drivers off
  assign hiz = {16'h0000, an_sel};

  // ==========================================================
  // Register writes. Mode bits of a shared pin keep their old
  // value, so a share cannot be broken by a stray mode write.
  always @* begin
    nxt_latch = latch_ff;
    nxt_mode_low = mode_low_ff;
    nxt_mode_high = mode_high_ff;
    if (wr_i) begin
      case (addr_i)
        `GIO_OFS_P1_DATA: begin
          nxt_latch[7:0] = wdata_i & `GIO_P1_MASK;
        end
        `GIO_OFS_P3_DATA: begin
          nxt_latch[15:8] = wdata_i & `GIO_P3_MASK;
        end
        `GIO_OFS_P4_DATA: begin
          nxt_latch[23:16] = wdata_i & `GIO_P4_MASK;
        end
        `GIO_OFS_P1_MODE_LOW: begin
          nxt_mode_low[7:0] = ((wdata_i & ~share[7:0]) |
            (mode_low_ff[7:0] & share[7:0])) &
            `GIO_P1_MASK;
        end
        `GIO_OFS_P1_MODE_HIGH: begin
          nxt_mode_high[7:0] = ((wdata_i & ~share[7:0]) |
            (mode_high_ff[7:0] & share[7:0])) &
            `GIO_P1_MASK;
        end
        `GIO_OFS_P3_MODE_LOW: begin
          nxt_mode_low[15:8] = ((wdata_i & ~share[15:8]) |
            (mode_low_ff[15:8] & share[15:8])) &
            `GIO_P3_MASK;
        end
        `GIO_OFS_P3_MODE_HIGH: begin
          nxt_mode_high[15:8] = ((wdata_i & ~share[15:8]) |
            (mode_high_ff[15:8] & share[15:8])) &
            `GIO_P3_MASK;
        end
        `GIO_OFS_P4_MODE_LOW: begin
          nxt_mode_low[23:16] = ((wdata_i & ~share[23:16]) |
            (mode_low_ff[23:16] & share[23:16])) &
            `GIO_P4_MASK;
        end
        `GIO_OFS_P4_MODE_HIGH: begin
          nxt_mode_high[23:16] = ((wdata_i & ~share[23:16]) |
            (mode_high_ff[23:16] & share[23:16])) &
            `GIO_P4_MASK;
        end
        default: begin
          nxt_latch = latch_ff;
        end
      endcase
    end
  end

  // ==========================================================
  // Register reads. A free pin returns its synced level; a
  // shared pin returns its latch, since the pad belongs to the
  // alternate function. Unmapped addresses read zero.
  always @* begin
    nxt_rdata = 8'h00;
    if (rd_i) begin
      case (addr_i)
        `GIO_OFS_P1_DATA: begin
          nxt_rdata = ((level[7:0] & ~share[7:0]) |
            (latch_ff[7:0] & share[7:0])) &
            `GIO_P1_MASK;
        end
        `GIO_OFS_P3_DATA: begin
          nxt_rdata = level[15:8] & `GIO_P3_MASK;
        end
        `GIO_OFS_P4_DATA: begin
          nxt_rdata = level[23:16] & `GIO_P4_MASK;
        end
        `GIO_OFS_P1_MODE_LOW: begin
          nxt_rdata = mode_low_ff[7:0];
        end
        `GIO_OFS_P1_MODE_HIGH: begin
          nxt_rdata = mode_high_ff[7:0];
        end
        `GIO_OFS_P3_MODE_LOW: begin
          nxt_rdata = mode_low_ff[15:8];
        end
        `GIO_OFS_P3_MODE_HIGH: begin
          nxt_rdata = mode_high_ff[15:8];
        end
        `GIO_OFS_P4_MODE_LOW: begin
          nxt_rdata = mode_low_ff[23:16];
        end
        `GIO_OFS_P4_MODE_HIGH: begin
          nxt_rdata = mode_high_ff[23:16];
        end
        default: begin
          nxt_rdata = 8'h00;
        end
      endcase
    end
  end

  // ==========================================================
  // State registers; clock enable low freezes everything
  always @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      latch_ff <= LATCH_RST_ALL;
      mode_low_ff <= MODE_LOW_RST_ALL;
      mode_high_ff <= MODE_HIGH_RST_ALL;
      rdata_o <= 8'h00;
      pin_level_o <= 24'h000000;
      analog_grant_o <= 8'h00;
      timer2_ext_pin_grant_o <= 1'b0;
      timer2_reload_capture_pin_grant_o <= 1'b0;
      low_voltage_detect_pin_grant_o <= 1'b0;
      ext_irq2_pin_grant_o <= 1'b0;
    end else if (ce_i) begin
      latch_ff <= nxt_latch;
      mode_low_ff <= nxt_mode_low;
      mode_high_ff <= nxt_mode_high;
      rdata_o <= nxt_rdata;
      pin_level_o <= level & IMPL_MASK;
      analog_grant_o <= nxt_an_grant;
      timer2_ext_pin_grant_o <= nxt_t2_pin_grant;
      timer2_reload_capture_pin_grant_o <= nxt_t2_reload_grant;
      low_voltage_detect_pin_grant_o <= nxt_lvd_grant;
      ext_irq2_pin_grant_o <= nxt_irq2_grant;
    end
  end

  // ==========================================================
  // One pad cell per implemented pin; the gaps stay idle
  genvar gi;
  generate
    for (gi = 0; gi < 24; gi = gi + 1) begin : g_pin
      if (IMPL_MASK[gi]) begin : g_impl
        gio_pin #(
          .RESET_LATCH(LATCH_RST_ALL[gi]),
          .RESET_MODE({MODE_LOW_RST_ALL[gi], MODE_HIGH_RST_ALL[gi]})
        ) u_pin (
          .core_clk_i(core_clk_i),
          .reset_i(reset_i),
          .ce_i(ce_i),
          .pad_i(pin_i[gi]),
          .latch_i(latch_ff[gi]),
          .mode_i({mode_low_ff[gi], mode_high_ff[gi]}),
          .hold_i(share[gi]),
          .hiz_i(hiz[gi]),
          .pad_o(pin_o[gi]),
          .pad_oe_o(pin_oe_o[gi]),
          .weak_pu_o(weak_pu_o[gi]),
          .vweak_pu_o(vweak_pu_o[gi]),
          .level_o(level[gi])
        );
      end else begin : g_none
        assign pin_o[gi] = 1'b0;
        assign pin_oe_o[gi] = 1'b0;
        assign weak_pu_o[gi] = 1'b0;
        assign vweak_pu_o[gi] = 1'b0;
        assign level[gi] = 1'b0;
      end
    end
  endgenerate

endmodule

// ==== gio_port_asserts.sv ====
`timescale 1ns/10ps
`include "gio_defines.vh"

// ==========================================================
// Port-level checks for the I/O port block
module gio_port_asserts (
  input wire core_clk_i,
  input wire reset_i,
  input wire ce_i,
  input wire [7:0] addr_i,
  input wire rd_i,
  input wire [7:0] rdata_o,
  input wire [23:0] pin_i,
  input wire [23:0] pin_o,
  input wire [23:0] pin_oe_o,
  input wire [23:0] weak_pu_o,
  input wire [23:0] vweak_pu_o,
  input wire [23:0] pin_level_o,
  input wire converter_on_i,
  input wire [2:0] channel_select_i,
  input wire [7:0] analog_channel_enable_i,
  input wire timer2_run_i,
  input wire timer2_counter_select_i,
  input wire timer2_ext_enable_i,
  input wire lvd_pin_select_i,
  input wire ext_irq2_enable_i,
  input wire [7:0] analog_grant_o,
  input wire timer2_ext_pin_grant_o,
  input wire timer2_reload_capture_pin_grant_o,
  input wire low_voltage_detect_pin_grant_o,
  input wire ext_irq2_pin_grant_o
);
  // Analog channel that the converter inputs ask for
  wire [7:0] an_want = analog_channel_enable_i &
    ({8{converter_on_i}} & (8'h01 << channel_select_i));
  wire [23:0] any_out = pin_o | pin_oe_o | weak_pu_o | vweak_pu_o;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);

  // ==========================================================
  // Register port
  sequence s_read;
    rd_i ##1 !rd_i;
  endsequence
  property p_rdata_one_cycle;
    s_read |=> rdata_o == 8'h00;
  endproperty
  a_rdata_one_cycle: assert property (p_rdata_one_cycle)
    else $error("read data stood longer than one cycle");
  property p_gap_bits;
    rd_i && (addr_i == `GIO_OFS_P3_DATA || addr_i == `GIO_OFS_P4_DATA) |=>
      (rdata_o & ~($past(addr_i) == `GIO_OFS_P3_DATA ?
      `GIO_P3_MASK : `GIO_P4_MASK)) == 8'h00;
  endproperty
  a_gap_bits: assert property (p_gap_bits)
    else $error("missing data bit read as one");

  // ==========================================================
  // Pins
  property p_unused_pins;
    (any_out[14] | pin_level_o[14]) == 1'b0 &&
      (any_out[23:19] | pin_level_o[23:19]) == 5'h00;
  endproperty
  a_unused_pins: assert property (p_unused_pins)
    else $error("missing pin position is active");
  // Sync lag is a few cycles, so wait for a settled pad first
  property p_level_follows;
    (ce_i && $stable(pin_i)) [*5] |->
      pin_level_o == (pin_i & {`GIO_P4_MASK, `GIO_P3_MASK, `GIO_P1_MASK});
  endproperty
  a_level_follows: assert property (p_level_follows)
    else $error("pin level does not follow the pad");
  // Drivers drop on the same edge that the grant rises
  property p_analog_quiet;
    (analog_grant_o & (pin_o[7:0] | pin_oe_o[7:0] | weak_pu_o[7:0] |
      vweak_pu_o[7:0])) == 8'h00;
  endproperty
  a_analog_quiet: assert property (p_analog_quiet)
    else $error("analog pin still driven or pulled");

  // ==========================================================
  // Share priority
  property p_analog_grant;
    ce_i |=> analog_grant_o == $past(an_want);
  endproperty
  a_analog_grant: assert property (p_analog_grant)
    else $error("analog grant wrong");
  property p_t2_ext_grant;
    ce_i |=> timer2_ext_pin_grant_o ==
      $past(timer2_run_i && timer2_counter_select_i && !an_want[7]);
  endproperty
  a_t2_ext_grant: assert property (p_t2_ext_grant)
    else $error("timer pin grant wrong");
  property p_t2_rc_grant;
    ce_i |=> timer2_reload_capture_pin_grant_o == $past(timer2_ext_enable_i
      && timer2_run_i && timer2_counter_select_i && !an_want[6]);
  endproperty
  a_t2_rc_grant: assert property (p_t2_rc_grant)
    else $error("timer reload pin grant wrong");
  property p_lvd_grant;
    ce_i |=> low_voltage_detect_pin_grant_o ==
      $past(lvd_pin_select_i && !an_want[3]);
  endproperty
  a_lvd_grant: assert property (p_lvd_grant)
    else $error("detect pin grant wrong");
  property p_irq2_grant;
    ce_i |=> ext_irq2_pin_grant_o == $past(ext_irq2_enable_i && !an_want[2]);
  endproperty
  a_irq2_grant: assert property (p_irq2_grant)
    else $error("interrupt pin grant wrong");
endmodule

bind gio_port gio_port_asserts gio_port_asserts_i (.core_clk_i, .reset_i,
  .ce_i, .addr_i, .rd_i, .rdata_o, .pin_i, .pin_o, .pin_oe_o, .weak_pu_o,
  .vweak_pu_o, .pin_level_o, .converter_on_i, .channel_select_i,
  .analog_channel_enable_i, .timer2_run_i, .timer2_counter_select_i,
  .timer2_ext_enable_i, .lvd_pin_select_i, .ext_irq2_enable_i,
  .analog_grant_o, .timer2_ext_pin_grant_o,
  .timer2_reload_capture_pin_grant_o, .low_voltage_detect_pin_grant_o,
  .ext_irq2_pin_grant_o);

// ==== gio_pad_model.sv ====
`timescale 1ns/10ps

// ==========================================================
// Board side of the pins: outside drivers and pull-ups
module gio_pad_model (
  input wire clk_i,
  input wire [23:0] drive_i,
  input wire [23:0] drive_oe_i,
  input wire [23:0] pull_i,
  input wire [23:0] ext_en_i,
  input wire [23:0] ext_val_i,
  input wire [23:0] ext_pu_i,
  output wire [23:0] pin_o
);
  reg [23:0] last_ff = 24'h000000;
  // Strong drive wins, then an outside driver, then any pull-up
  assign pin_o = (drive_oe_i & drive_i)
    | (~drive_oe_i & ext_en_i & ext_val_i)
    | (~drive_oe_i & ~ext_en_i & (pull_i | ext_pu_i))
    | (~drive_oe_i & ~ext_en_i & ~pull_i & ~ext_pu_i & ~last_ff);
  // A floating pad holds nothing, so show the inverse of the last level
  always @(posedge clk_i) begin
    last_ff <= pin_o;
  end
endmodule

// ==== test_gio_port.sv ====
`timescale 1ns/10ps
`include "gio_defines.vh"

// ==========================================================
// Self-checking bench for the I/O port block
module test_gio_port;
  localparam [159:0] RST_TBL = {16'h90FF, 16'hB0BF, 16'hC007, 16'hE200,
    16'hE400, 16'hE500, 16'hEA00, 16'hEC00, 16'hED00, 16'h9100};
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg [7:0] addr = 8'h00;
  reg [7:0] wdata = 8'h00;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg conv = 1'b0;
  reg [2:0] sel = 3'h0;
  reg [7:0] an_en = 8'h00;
  reg run = 1'b0;
  reg cs = 1'b0;
  reg tmr_ext = 1'b0;
  reg lvd = 1'b0;
  reg irq = 1'b0;
  reg [23:0] ext_en = 24'h000000;
  reg [23:0] ext_val = 24'h000000;
  reg [7:0] e8;
  wire [7:0] rdata;
  wire [23:0] pin, drv, oe, wpu, vpu;
  wire [7:0] agr;
  wire [3:0] gr;
  integer fail_count = 0;
  integer num_checks = 0;
  integer i;
  integer k;

  gio_port gio_port_i (.core_clk_i(clk), .reset_i(rst), .ce_i(1'b1),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .pin_i(pin), .pin_o(drv), .pin_oe_o(oe), .weak_pu_o(wpu),
    .vweak_pu_o(vpu), .pin_level_o(), .converter_on_i(conv),
    .channel_select_i(sel), .analog_channel_enable_i(an_en),
    .timer2_run_i(run), .timer2_counter_select_i(cs),
    .timer2_ext_enable_i(tmr_ext), .lvd_pin_select_i(lvd),
    .ext_irq2_enable_i(irq), .analog_grant_o(agr),
    .timer2_ext_pin_grant_o(gr[3]), .timer2_reload_capture_pin_grant_o(gr[2]),
    .low_voltage_detect_pin_grant_o(gr[1]), .ext_irq2_pin_grant_o(gr[0]));

  gio_pad_model gio_pad_model_i (.clk_i(clk), .drive_i(drv),
    .drive_oe_i(oe), .pull_i(wpu | vpu), .ext_en_i(ext_en),
    .ext_val_i(ext_val), .ext_pu_i(24'hFFFFFF), .pin_o(pin));

  // Free-running clock
  always #5 clk = ~clk;

  // ==========================================================
  // Tasks
  task chk(input [23:0] got, input [23:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task wr_reg(input [7:0] a, input [7:0] d);
    begin
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
    end
  endtask
  // Read data stand only in the cycle after the strobe
  task rd_chk(input [7:0] a, input [7:0] exp);
    begin
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(rdata, exp);
    end
  endtask
  task end_of_test;
    begin
      if (fail_count == 0 && num_checks > 0) begin
        $display("No errors found");
      end else begin
        $display("Errors were found");
      end
      $finish;
    end
  endtask
  // Expected {oe, drive, weak, very weak} of a pin for mode and latch
  function [3:0] mode_exp(input [1:0] m, input l);
    case (m)
      `GIO_MODE_QUASI: mode_exp = l ? 4'h7 : 4'h8;
      `GIO_MODE_PUSH: mode_exp = {1'h1, l, 2'h0};
      `GIO_MODE_INPUT: mode_exp = 4'h0;
      default: mode_exp = {~l, 3'h0};
    endcase
  endfunction

  // Hang guard
  initial begin
    #200000;
    fail_count = fail_count + 1;
    end_of_test;
  end

  // ==========================================================
  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    for (i = 0; i < 10; i = i + 1) begin
      rd_chk(RST_TBL[i*16+8 +: 8], RST_TBL[i*16 +: 8]);
    end
    chk(vpu, 24'h07BFFF);
    chk(oe, 24'h000000);
    // Port3 pin 0 through every mode and latch level
    for (i = 0; i < 8; i = i + 1) begin
      ext_en[8] <= (i[2:1] == `GIO_MODE_INPUT);
      ext_val[8] <= ~i[0];
      wr_reg(`GIO_OFS_P3_MODE_LOW, {7'h00, i[2]});
      wr_reg(`GIO_OFS_P3_MODE_HIGH, {7'h00, i[1]});
      wr_reg(`GIO_OFS_P3_DATA, {7'h5F, i[0]});
      repeat (6) @(posedge clk);
      #1 chk({oe[8], drv[8], wpu[8], vpu[8]}, mode_exp(i[2:1], i[0]));
      rd_chk(`GIO_OFS_P3_MODE_HIGH, {7'h00, i[1]});
      rd_chk(`GIO_OFS_P3_DATA, {7'h5F, i[0] ^ (i[2:1] == 2)});
    end
    // Strong pull-up burst on a quasi 0 to 1 latch change
    wr_reg(`GIO_OFS_P3_MODE_LOW, 8'h00);
    wr_reg(`GIO_OFS_P3_MODE_HIGH, 8'h00);
    wr_reg(`GIO_OFS_P3_DATA, 8'hBE);
    wr_reg(`GIO_OFS_P3_DATA, 8'hBF);
    k = 0;
    repeat (8) begin
      @(posedge clk);
      #1 k = k + (oe[8] & drv[8]);
    end
    chk(k[23:0], `GIO_STRONG_CYC);
    ext_val[8] <= 1'b0;
    ext_en[8] <= 1'b1;
    repeat (6) @(posedge clk);
    #1 chk({oe[8], drv[8], wpu[8], vpu[8]}, 4'h5);
    ext_en[8] <= 1'b0;
    // Share priority sweep; analog lock-out and hand-back
    @(posedge clk);
    {run, tmr_ext, lvd, irq} <= 4'hF;
    for (i = 0; i < 64; i = i + 1) begin
      @(posedge clk);
      an_en <= i[5] ? 8'h5A : 8'hA5;
      conv <= i[3];
      sel <= i[2:0];
      cs <= i[4];
      repeat (2) @(posedge clk);
      e8 = an_en & {8{conv}} & (8'h01 << sel);
      #1 chk(agr, e8);
      chk(gr[3:2], {cs & ~e8[7], cs & ~e8[6]});
      chk(gr[1:0], {~e8[3], ~e8[2]});
    end
    // Shared pin: latch and mode writes must not reach the pad
    @(posedge clk);
    {run, cs, tmr_ext, lvd, conv} <= 5'h00;
    wr_reg(`GIO_OFS_P1_DATA, 8'hFB);
    wr_reg(`GIO_OFS_P1_MODE_LOW, 8'h04);
    repeat (6) @(posedge clk);
    #1 chk({oe[2], drv[2], gr}, 6'h11);
    rd_chk(`GIO_OFS_P1_MODE_LOW, 8'h00);
    rd_chk(`GIO_OFS_P1_DATA, 8'hFB);
    @(posedge clk);
    irq <= 1'b0;
    repeat (6) @(posedge clk);
    #1 chk({oe[2], drv[2], gr}, 6'h20);
    wr_reg(`GIO_OFS_P1_MODE_LOW, 8'h04);
    rd_chk(`GIO_OFS_P1_MODE_LOW, 8'h04);
    end_of_test;
  end
endmodule
